/* File: pkg/rfflag_pkg.sv */
// Package for the regulator fault flag registers.
// Holds register offsets, bit positions, reset values and timing counts.
// Assumes a single 250 MHz clock domain for every user.
package rfflag_pkg;
    // Register offsets on the internal register port
    localparam logic [7:0] OFF_TOP1 = 8'h19;
    localparam logic [7:0] OFF_TOP2 = 8'h1a;
    localparam logic [7:0] OFF_CONV = 8'h1b;
    localparam logic [7:0] OFF_LIN = 8'h1c;
    localparam logic [7:0] OFF_STAT = 8'h1d;
    // Reset value of every flag register
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // Bit positions inside the converter and regulator registers
    localparam int BIT_PG1 = 6;
    localparam int BIT_SC1 = 5;
    localparam int BIT_IL1 = 4;
    localparam int BIT_PG0 = 2;
    localparam int BIT_SC0 = 1;
    localparam int BIT_IL0 = 0;
    // Writable flag bits (reserved bits 7 and 3 stay zero)
    localparam logic [7:0] FLAG_MASK = 8'h77;
    // Reset event bit in second top register
    localparam int BIT_RST_EV = 0;
    // Summary bits in first top register
    localparam int BIT_LIN_SUM = 6;
    localparam int BIT_CONV_SUM = 5;
    // Short-circuit qualification time
    localparam int SC_TIME_US = 1000;
    localparam int CLK_MHZ = 250;
    // Strictly longer than 1 ms: one cycle beyond the bare count
    localparam int SC_CYCLES = SC_TIME_US * CLK_MHZ + 1;
    // Length of the reset-sequencing pulse driven to the regulators
    localparam int SEQ_CYCLES = 16;
endpackage

/* File: core/rfflag_regs.sv */
// Latched event flag registers of the power-management core.
// Assumes detector inputs are synchronous to mclk and a simple
// internal register port: reg_wr pulse with address and data, read data
// combinationally selected and registered one cycle after reg_rd.
// The analog detectors and the chip-wide register defaults live outside;
// this block only orders them through its sequencing outputs, which are
// levels except for the one-cycle startup pulse.
`timescale 1ns/1ps

// Behaviour
// - Writing one clears a flag; zero keeps
// - Undervoltage or software request sets reset flag
// - Reset event disables regulators, defaults, restarts
// - Converter power-good events latch bits 6, 2
// - Converter short over 1 ms latches 5, 1
// - Converter current-limit events latch bits 4, 0
// - Regulator power-good events latch bits 6, 2
// - Regulator short over 1 ms latches 5, 1
// - Regulator current-limit events latch bits 4, 0
// - Reserved bits 7 and 3 read zero
// - Converter summary clears when converter flags zero
// - Regulator summary clears when regulator flags zero
module rfflag_regs #(
    parameter int SC_CYCLES = rfflag_pkg::SC_CYCLES
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Detectors: index 1 is unit one, index 0 unit zero
    // All detector inputs are already synchronous to mclk
    input wire logic analog_supply_uv,
    input wire logic software_reset_request,
    input wire logic [1:0] conv_pg_event,
    input wire logic [1:0] conv_below_sc,
    input wire logic [1:0] conv_ilim_active,
    input wire logic [1:0] lin_pg_event,
    input wire logic [1:0] lin_below_sc,
    input wire logic [1:0] lin_ilim_active,
    input wire logic [7:0] top_live_status,
    // Reset sequencing towards the rest of the chip
    output logic regulators_off,
    output logic regs_to_default,
    output logic startup_run,
    // Summary and flags for the interrupt logic
    output logic conv_summary,
    output logic linear_summary_flag,
    output logic reset_event_flag
);
    // Sequencer states, one-hot so a stray code falls to the default branch
    // Idle waits for a request, hold keeps regulators off and defaults applied,
    // start is the single cycle that launches the normal power-up order
    typedef enum logic [2:0] {
        RFF_IDLE = 3'b001,
        RFF_HOLD = 3'b010,
        RFF_START = 3'b100
    } rfflag_seq_t;

    // Flag registers and next values
    logic [7:0] conv_flags_r, conv_flags_nxt;
    logic [7:0] lin_flags_r, lin_flags_nxt;
    // Reset-event flag lives apart, it survives the default restore
    logic rst_flag_r, rst_flag_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    // Sequencer state and length counter
    rfflag_seq_t seq_r, seq_nxt;
    logic [4:0] seq_cnt_r, seq_cnt_nxt;
    logic off_r, off_nxt, dflt_r, dflt_nxt, run_r, run_nxt;
    // Short-circuit qualify counters, converters at 0..1, regulators 2..3
    logic [3:0] below_sc;
    logic [3:0] sc_hit;
    logic [31:0] sc_cnt_r [4];
    logic [31:0] sc_cnt_nxt [4];
    // Event vectors built from the detectors
    logic [7:0] conv_set, lin_set;
    logic reset_req;
    // Write strobes decoded per register
    logic wr_conv, wr_lin, wr_top2;

    assign below_sc = {lin_below_sc, conv_below_sc};

    // One qualifying timer per monitored output
    // Counters are wide enough for the full qualifying time at 250 MHz;
    // a counter that reaches its limit stops there, so a long short keeps
    // its hit asserted and re-arms only when the output recovers
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sc
            always_comb begin
                // Count while below, restart when output recovers
                // Hit is combinational and latches into a flag on the next edge
                sc_cnt_nxt[gi] = sc_cnt_r[gi];
                sc_hit[gi] = 1'b0;
                if (!below_sc[gi]) begin
                    sc_cnt_nxt[gi] = 32'h0000_0000;
                end else if (sc_cnt_r[gi] >= 32'(SC_CYCLES - 1)) begin
                    sc_hit[gi] = 1'b1;
                end else begin
                    sc_cnt_nxt[gi] = sc_cnt_r[gi] + 32'h0000_0001;
                end
            end
            // Timer registers, frozen with the rest while clk_en is low
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    sc_cnt_r[gi] <= 32'h0000_0000;
                end else if (clk_en) begin
                    sc_cnt_r[gi] <= sc_cnt_nxt[gi];
                end
            end
        end
    endgenerate

    // Event vector assembly in register bit order
    // Reserved positions stay zero here and are masked again at the flops
    // Either reset source alone is enough to start the sequence
    always_comb begin
        conv_set = 8'h00;
        lin_set = 8'h00;
        conv_set[rfflag_pkg::BIT_PG1] = conv_pg_event[1];
        conv_set[rfflag_pkg::BIT_PG0] = conv_pg_event[0];
        conv_set[rfflag_pkg::BIT_SC1] = sc_hit[1];
        conv_set[rfflag_pkg::BIT_SC0] = sc_hit[0];
        conv_set[rfflag_pkg::BIT_IL1] = conv_ilim_active[1];
        conv_set[rfflag_pkg::BIT_IL0] = conv_ilim_active[0];
        // Regulator events use the same bit layout as the converters
        lin_set[rfflag_pkg::BIT_PG1] = lin_pg_event[1];
        lin_set[rfflag_pkg::BIT_PG0] = lin_pg_event[0];
        lin_set[rfflag_pkg::BIT_SC1] = sc_hit[3];
        lin_set[rfflag_pkg::BIT_SC0] = sc_hit[2];
        lin_set[rfflag_pkg::BIT_IL1] = lin_ilim_active[1];
        lin_set[rfflag_pkg::BIT_IL0] = lin_ilim_active[0];
        reset_req = analog_supply_uv | software_reset_request;
    end

    // Address decode of write strobes
    // Writes to the summary and live status offsets decode to nothing,
    // so those registers cannot be disturbed from the register port
    assign wr_conv = reg_wr && (reg_addr == rfflag_pkg::OFF_CONV);
    assign wr_lin = reg_wr && (reg_addr == rfflag_pkg::OFF_LIN);
    assign wr_top2 = reg_wr && (reg_addr == rfflag_pkg::OFF_TOP2);

    // Flag next values: clear by ones, then set wins
    // Order matters: clearing first and setting last keeps an event that
    // lands on the clearing write, so that write never drops a fault
    always_comb begin
        conv_flags_nxt = conv_flags_r;
        lin_flags_nxt = lin_flags_r;
        rst_flag_nxt = rst_flag_r;
        if (wr_conv) begin
            conv_flags_nxt = conv_flags_r & ~reg_wdata;
        end
        if (wr_lin) begin
            lin_flags_nxt = lin_flags_r & ~reg_wdata;
        end
        // Only bit 0 of the second top register is a flag
        if (wr_top2 && reg_wdata[rfflag_pkg::BIT_RST_EV]) begin
            rst_flag_nxt = 1'b0;
        end
        // Set after clear so a coincident event is kept
        conv_flags_nxt = (conv_flags_nxt | conv_set) & rfflag_pkg::FLAG_MASK;
        lin_flags_nxt = (lin_flags_nxt | lin_set) & rfflag_pkg::FLAG_MASK;
        if (reset_req) begin
            rst_flag_nxt = 1'b1;
        end
        // Default restore: event flags wiped, reset flag kept
        // Events seen while holding latch for one cycle; only those in the last hold cycle are kept
        if (seq_r == RFF_HOLD) begin
            conv_flags_nxt = conv_set & rfflag_pkg::FLAG_MASK;
            lin_flags_nxt = lin_set & rfflag_pkg::FLAG_MASK;
        end
    end

    // Read mux, registered; unmapped offsets read zero
    // Read data holds between reads, so a slow host may sample it late;
    // the summary byte carries only its two summary bits
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                rfflag_pkg::OFF_TOP1: begin
                    rdata_nxt = 8'h00;
                    rdata_nxt[rfflag_pkg::BIT_LIN_SUM] = |lin_flags_r;
                    rdata_nxt[rfflag_pkg::BIT_CONV_SUM] = |conv_flags_r;
                end
                rfflag_pkg::OFF_TOP2: rdata_nxt = {7'h00, rst_flag_r};
                rfflag_pkg::OFF_CONV: rdata_nxt = conv_flags_r;
                rfflag_pkg::OFF_LIN: rdata_nxt = lin_flags_r;
                rfflag_pkg::OFF_STAT: rdata_nxt = top_live_status;
                // Offsets outside the map return zero, never stale data
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Reset-event sequencer: regulators off, defaults, then startup
    // The hold length counts from the last cycle of the request, which
    // trades a longer hold for never starting while the supply is low
    always_comb begin
        seq_nxt = seq_r;
        seq_cnt_nxt = seq_cnt_r;
        off_nxt = off_r;
        dflt_nxt = 1'b0;
        run_nxt = 1'b0;
        // Off level persists; defaults and start are rebuilt each cycle
        case (seq_r)
            RFF_IDLE: begin
                // First cycle of a request: regulators off, defaults applied
                if (reset_req) begin
                    seq_nxt = RFF_HOLD;
                    seq_cnt_nxt = 5'h00;
                    off_nxt = 1'b1;
                    dflt_nxt = 1'b1;
                end
            end
            RFF_HOLD: begin
                // Held while the request persists, so a long brownout waits
                dflt_nxt = 1'b1;
                if (reset_req) begin
                    seq_cnt_nxt = 5'h00;
                end else if (seq_cnt_r == 5'(rfflag_pkg::SEQ_CYCLES - 1)) begin
                    // Hold time spent: release regulators and launch startup
                    seq_nxt = RFF_START;
                    dflt_nxt = 1'b0;
                    off_nxt = 1'b0;
                    run_nxt = 1'b1;
                end else begin
                    seq_cnt_nxt = seq_cnt_r + 5'h01;
                end
            end
            RFF_START: begin
                // A request in the launch cycle restarts the hold at once,
                // otherwise a one-cycle request here would be dropped
                if (reset_req) begin
                    seq_nxt = RFF_HOLD;
                    seq_cnt_nxt = 5'h00;
                    off_nxt = 1'b1;
                    dflt_nxt = 1'b1;
                end else begin
                    seq_nxt = RFF_IDLE;
                end
            end
            default: begin
                // Unreachable codes recover to idle with regulators released
                seq_nxt = RFF_IDLE;
                off_nxt = 1'b0;
            end
        endcase
    end

    // State registers for flags, read data and sequencer
    // Clock enable low freezes every flop, including the qualifying timers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // Every flop returns to zero except the sequencer, which returns to idle; the reset flag included
            conv_flags_r <= rfflag_pkg::FLAGS_RST;
            lin_flags_r <= rfflag_pkg::FLAGS_RST;
            rst_flag_r <= 1'b0;
            rdata_r <= 8'h00;
            seq_r <= RFF_IDLE;
            seq_cnt_r <= 5'h00;
            off_r <= 1'b0;
            dflt_r <= 1'b0;
            run_r <= 1'b0;
        end else if (clk_en) begin
            conv_flags_r <= conv_flags_nxt;
            lin_flags_r <= lin_flags_nxt;
            rst_flag_r <= rst_flag_nxt;
            rdata_r <= rdata_nxt;
            seq_r <= seq_nxt;
            seq_cnt_r <= seq_cnt_nxt;
            off_r <= off_nxt;
            dflt_r <= dflt_nxt;
            run_r <= run_nxt;
        end
    end

    // Summaries are OR of flag flops; each comes from a flop of its own
    // Built from the next values so the summary flop and the flag flops
    // change on the same edge, with no cycle of lag for the host to see;
    // the read mux rebuilds the same summaries from the flag flops
    logic conv_sum_r, lin_sum_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            conv_sum_r <= 1'b0;
            lin_sum_r <= 1'b0;
        end else if (clk_en) begin
            conv_sum_r <= |conv_flags_nxt;
            lin_sum_r <= |lin_flags_nxt;
        end
    end

    // Every output is a plain copy of a flop, no logic after the registers
    assign reg_rdata = rdata_r;
    assign regulators_off = off_r;
    assign regs_to_default = dflt_r;
    assign startup_run = run_r;
    assign conv_summary = conv_sum_r;
    assign linear_summary_flag = lin_sum_r;
    assign reset_event_flag = rst_flag_r;
endmodule

/* File: testbench/rfflag_regs_assertions.sv */
// Port-level checker for the flag registers.
// Assumes it is bound onto rfflag_regs and sees one mclk domain.
`timescale 1ns/1ps
module rfflag_chk (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Detectors
    input wire logic analog_supply_uv,
    input wire logic software_reset_request,
    input wire logic [1:0] conv_pg_event,
    input wire logic [1:0] conv_below_sc,
    input wire logic [1:0] conv_ilim_active,
    input wire logic [1:0] lin_ilim_active,
    // Outputs watched
    input wire logic regulators_off,
    input wire logic regs_to_default,
    input wire logic startup_run,
    input wire logic conv_summary,
    input wire logic linear_summary_flag,
    input wire logic reset_event_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Either reset source; a clear write loses against it
    logic rq;
    assign rq = analog_supply_uv | software_reset_request;
    a_ilim_sets_sum: assert property (clk_en && conv_ilim_active != 2'h0 |=> conv_summary)
        else $error("current limit did not raise converter summary");
    a_lin_sets_sum: assert property (clk_en && lin_ilim_active != 2'h0 |=> linear_summary_flag)
        else $error("current limit did not raise regulator summary");
    a_pg_sets_sum: assert property (clk_en && conv_pg_event != 2'h0 |=> conv_summary)
        else $error("power-good event did not raise converter summary");
    a_reset_seq_start: assert property (clk_en && rq |=> reset_event_flag && regulators_off && regs_to_default)
        else $error("reset event did not start the sequence");
    a_reset_flag_holds: assert property (reset_event_flag && clk_en
        && !(reg_wr && reg_addr == 8'h1a && reg_wdata[0]) |=> reset_event_flag)
        else $error("reset flag dropped without a clear");
    a_reset_flag_clear: assert property (clk_en && !rq && !regs_to_default && reg_wr
        && reg_addr == 8'h1a && reg_wdata[0] |=> !reset_event_flag)
        else $error("reset flag not cleared by a written one");
    a_conv_all_clear: assert property (clk_en && !rq && reg_wr && reg_addr == 8'h1b
        && reg_wdata == 8'hff && {conv_pg_event, conv_ilim_active, conv_below_sc} == 6'h00
        |=> !conv_summary)
        else $error("converter summary stuck after full clear");
    a_reserved_read_zero: assert property (clk_en && reg_rd && reg_addr inside {8'h1b, 8'h1c}
        |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("reserved bit read as one");
    a_startup_one_cycle: assert property (clk_en && startup_run |=> !startup_run)
        else $error("startup pulse longer than one cycle");
    c_reset_event: cover property (clk_en && rq);
    c_startup: cover property (startup_run);
    c_conv_sum: cover property ($rose(conv_summary));
endmodule

/* File: testbench/test_rfflag_regs.sv */
// Self-checking bench for the flag registers, random and corner cases.
// Assumes rfflag_regs and rfflag_chk are compiled before it.
`timescale 1ns/1ps
module test_rfflag_regs;
    // Stimulus and observed signals
    logic mclk = 1'h0, rst = 1'h1, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, top_live_status = 8'h00;
    logic analog_supply_uv = 1'h0, software_reset_request = 1'h0;
    logic [1:0] conv_pg_event = 2'h0, conv_below_sc = 2'h0, conv_ilim_active = 2'h0;
    logic [1:0] lin_pg_event = 2'h0, lin_below_sc = 2'h0, lin_ilim_active = 2'h0;
    logic regulators_off, regs_to_default, startup_run, conv_summary;
    logic linear_summary_flag, reset_event_flag;
    // Expected flag images
    logic [7:0] ec, el;
    int error_cnt = 0, checks_done = 0, seed = 99074, r, w, n, k;
    always #2 mclk = ~mclk;
    // Short qualification shortened to keep the run brief
    rfflag_regs #(.SC_CYCLES(8)) DUT (.*);
    // Flag image for one register from per-unit events
    function automatic logic [7:0] fl(logic [1:0] pg, logic [1:0] sc, logic [1:0] il);
        return {1'h0, pg[1], sc[1], il[1], 1'h0, pg[0], sc[0], il[0]};
    endfunction
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One register access, called and left at a falling edge
    task automatic acc(logic wr, logic [7:0] a, logic [7:0] d);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        // One idle cycle so back-to-back calls never reassign a strobe at once
        @(negedge mclk);
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [7:0] exp);
        acc(1'h0, a, 8'h00);
        chk(nm, exp, reg_rdata);
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        rst = 1'h0;
        rdc("conv", 8'h1b, 8'h00);
        rdc("lin", 8'h1c, 8'h00);
        rdc("top2", 8'h1a, 8'h00);
        rdc("unmapped", 8'h3c, 8'h00);
        ec = 8'h00;
        el = 8'h00;
        // Random events, some landing on a clearing write
        for (n = 0; n < 30; n++) begin
            r = $random(seed);
            w = $random(seed);
            top_live_status = r[15:8];
            {conv_pg_event, conv_ilim_active, lin_pg_event, lin_ilim_active} = r[7:0];
            if (n % 3 == 0) acc(1'h1, 8'h1b, w[7:0]);
            else @(negedge mclk);
            {conv_pg_event, conv_ilim_active, lin_pg_event, lin_ilim_active} = 8'h00;
            ec = fl(r[7:6], 2'h0, r[5:4]) | (ec & ~((n % 3 == 0) ? w[7:0] : 8'h00));
            el = el | fl(r[3:2], 2'h0, r[1:0]);
            chk("conv sum", {7'h00, ec != 8'h00}, {7'h00, conv_summary});
            chk("lin sum", {7'h00, el != 8'h00}, {7'h00, linear_summary_flag});
            rdc("conv", 8'h1b, ec);
            rdc("lin", 8'h1c, el);
            rdc("top1", 8'h19, {1'h0, el != 8'h00, ec != 8'h00, 5'h00});
            rdc("status", 8'h1d, r[15:8]);
            acc(1'h1, 8'h1b, w[15:8]);
            ec = ec & ~w[15:8];
            acc(1'h1, 8'h1c, w[23:16]);
            el = el & ~w[23:16];
        end
        // Short flags need more than the qualifying time
        for (n = 0; n < 2; n++) begin
            acc(1'h1, 8'h1b, 8'hff);
            acc(1'h1, 8'h1c, 8'hff);
            for (k = 7; k < 10; k += 2) begin
                conv_below_sc = n ? 2'h2 : 2'h1;
                lin_below_sc = conv_below_sc;
                repeat (k) @(negedge mclk);
                conv_below_sc = 2'h0;
                lin_below_sc = 2'h0;
                rdc("conv sc", 8'h1b, (k == 9) ? fl(2'h0, n ? 2'h2 : 2'h1, 2'h0) : 8'h00);
                rdc("lin sc", 8'h1c, (k == 9) ? fl(2'h0, n ? 2'h2 : 2'h1, 2'h0) : 8'h00);
            end
        end
        // Both reset sources, event flags set beforehand only for the software request pass
        for (n = 0; n < 2; n++) begin
            acc(1'h1, 8'h1a, 8'h01);
            {analog_supply_uv, software_reset_request} = n ? 2'h2 : 2'h1;
            @(negedge mclk);
            {analog_supply_uv, software_reset_request} = 2'h0;
            chk("seq", 8'h07, {5'h00, reset_event_flag, regulators_off, regs_to_default});
            k = 0;
            while (startup_run !== 1'h1 && k < 40) begin
                @(negedge mclk);
                k++;
            end
            if (k == 40) begin
                error_cnt++;
                $display("mismatch startup_run expected 1 seen 0");
                close_out();
            end
            chk("seq len", 8'(rfflag_pkg::SEQ_CYCLES), 8'(k));
            @(negedge mclk);
            chk("seq end", 8'h00, {6'h00, regulators_off, regs_to_default});
            rdc("conv", 8'h1b, 8'h00);
            rdc("top2", 8'h1a, 8'h01);
            acc(1'h1, 8'h1a, 8'hfe);
            rdc("top2", 8'h1a, 8'h01);
        end
        // Frozen clock enable ignores events
        clk_en = 1'h0;
        conv_ilim_active = 2'h3;
        repeat (2) @(negedge mclk);
        conv_ilim_active = 2'h0;
        clk_en = 1'h1;
        chk("frozen", 8'h00, {7'h00, conv_summary});
        // Reset in mid-run wipes the reset-event flag as well
        rst = 1'h1;
        @(negedge mclk);
        rst = 1'h0;
        rdc("top2 after rst", 8'h1a, 8'h00);
        close_out();
    end
endmodule
bind rfflag_regs rfflag_chk u_chk (.*);
